/* File: include/dac_link_pkg.sv */
// constants, field layout and register map for the quad converter serial update control
package dac_link_pkg;

  // serial frame
  localparam int unsigned FRAME_BITS   = 16;
  localparam int unsigned CNT_W        = 5;
  localparam int unsigned CODE_W       = 8;
  localparam int unsigned NUM_CH       = 4;
  localparam int unsigned SYNC_STAGES  = 2;

  // field positions within the 16-bit word, shifted msb first
  localparam int unsigned ADDR_MSB     = 15;
  localparam int unsigned ADDR_LSB     = 14;
  localparam int unsigned MODE_MSB     = 13;
  localparam int unsigned MODE_LSB     = 12;
  localparam int unsigned CODE_MSB     = 11;
  localparam int unsigned CODE_LSB     = 4;

  // operating modes
  localparam logic [1:0] MODE_HOLD     = 2'h0;
  localparam logic [1:0] MODE_SINGLE   = 2'h1;
  localparam logic [1:0] MODE_ALL      = 2'h2;
  localparam logic [1:0] MODE_PDOWN    = 2'h3;

  // power-down termination options, carried in the channel field
  localparam logic [1:0] PD_RESERVED   = 2'h0;
  localparam logic [1:0] PD_LOW_OHMS   = 2'h1;
  localparam logic [1:0] PD_HIGH_OHMS  = 2'h2;
  localparam logic [1:0] PD_OPEN       = 2'h3;

  // register map, byte addresses
  localparam int unsigned ADDR_W       = 12;
  localparam logic [11:0] OFS_CTRL     = 12'h000;
  localparam logic [11:0] OFS_STATUS   = 12'h004;
  localparam logic [11:0] OFS_CODES    = 12'h008;
  localparam logic [11:0] OFS_LAST     = 12'h00c;
  localparam logic [11:0] OFS_PENDING  = 12'h010;

  // control fields and reset values
  localparam int unsigned CTRL_EN_BIT  = 0;
  localparam int unsigned CTRL_CLR_BIT = 1;
  localparam logic        CTRL_EN_RST  = 1'b1;

  // status fields
  localparam int unsigned ST_DONE_LSB  = 0;
  localparam int unsigned ST_ABORT_LSB = 8;
  localparam int unsigned ST_BUSY_BIT  = 16;
  localparam int unsigned ST_PD_BIT    = 17;
  localparam int unsigned ST_PDO_LSB   = 18;

  localparam logic [7:0]  CODE_RST     = 8'h00;
  localparam logic [31:0] DATA_ZERO    = 32'h0000_0000;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_SHIFT = 2'b01,
    ST_SPENT = 2'b11
  } link_state_t;

endpackage

/* File: verilog/pin_sync.sv */
// two-stage synchroniser for one pin input
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic ce,
  input  wire logic pin,
  output var  logic level
);
  logic meta_q;

  // only the second stage reads the first
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_q <= RESET_VAL;
      level  <= RESET_VAL;
    end else if (ce) begin
      meta_q <= pin;
      level  <= meta_q;
    end
  end
endmodule
`default_nettype wire

/* File: verilog/dac_update_ctrl.sv */
// serial frame receiver and output update control for a quad 8-bit converter
//
// Notes on behaviour
// - a 16-bit shift register holds channel, mode, power-down choice and code
// - four output channels each hold an 8-bit code; one reference serves all
// - shifting is enabled only while frame select is low
// - data is sampled on each falling serial clock edge after select falls
// - the update is made on the sixteenth clock of the frame
// - select rising before the sixteenth clock discards the partial frame
// - two mode bits choose single-channel or simultaneous update of all four
// - after reset every output holds zero until the first complete valid write
// - a power-down command offers three termination choices
//
// The APB interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module dac_update_ctrl
  import dac_link_pkg::*;
(
  input  wire logic                            clk,
  input  wire logic                            resetn,
  input  wire logic                            ce,
  // three-wire link, all asynchronous to clk
  input  wire logic                            frame_sel_n,
  input  wire logic                            serial_clk,
  input  wire logic                            serial_din,
  // apb slave
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire logic [dac_link_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                     pwdata,
  output var  logic [31:0]                     prdata,
  output var  logic                            pready,
  output var  logic                            pslverr,
  // converter codes and power-down state
  output var  logic [dac_link_pkg::CODE_W-1:0] channel_a_output,
  output var  logic [dac_link_pkg::CODE_W-1:0] channel_b_output,
  output var  logic [dac_link_pkg::CODE_W-1:0] channel_c_output,
  output var  logic [dac_link_pkg::CODE_W-1:0] channel_d_output,
  output var  logic                            power_down,
  output var  logic [1:0]                      pd_option
);
  import dac_link_pkg::*;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic sel_n_s;
  logic sclk_s;
  logic din_s;

  pin_sync #(.RESET_VAL(1'b1)) u_sync_sel (
    .clk    (clk),
    .resetn (resetn),
    .ce     (ce),
    .pin    (frame_sel_n),
    .level  (sel_n_s)
  );

  pin_sync #(.RESET_VAL(1'b0)) u_sync_sclk (
    .clk    (clk),
    .resetn (resetn),
    .ce     (ce),
    .pin    (serial_clk),
    .level  (sclk_s)
  );

  pin_sync #(.RESET_VAL(1'b0)) u_sync_din (
    .clk    (clk),
    .resetn (resetn),
    .ce     (ce),
    .pin    (serial_din),
    .level  (din_s)
  );

  // edge history on the synchronised copies only
  logic sel_n_d1_q;
  logic sclk_d1_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sel_n_d1_q <= 1'b1;
      sclk_d1_q  <= 1'b0;
    end else if (ce) begin
      sel_n_d1_q <= sel_n_s;
      sclk_d1_q  <= sclk_s;
    end
  end

  logic sclk_fall;
  logic sel_fall;
  logic sel_rise;
  logic link_en_q;

  // din passes the same two stages as sclk, so it is aligned with the edge seen here
  assign sclk_fall = sclk_d1_q & ~sclk_s;
  assign sel_fall  = sel_n_d1_q & ~sel_n_s;
  assign sel_rise  = ~sel_n_d1_q & sel_n_s;

  // ---------------------------------------------------------------
  // frame state machine and shift register
  // ---------------------------------------------------------------
  link_state_t           state_q;
  logic [FRAME_BITS-1:0] shift_q;
  logic [CNT_W-1:0]      bit_cnt_q;
  logic                  word_done;
  logic                  frame_abort;
  logic [FRAME_BITS-1:0] word;

  localparam logic [CNT_W-1:0] LAST_BIT = CNT_W'(FRAME_BITS - 1);

  assign word        = {shift_q[FRAME_BITS-2:0], din_s};
  assign word_done   = (state_q == ST_SHIFT) && sclk_fall && !sel_n_s
                       && (bit_cnt_q == LAST_BIT);
  assign frame_abort = (state_q == ST_SHIFT) && sel_rise;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
    end else if (ce) begin
      unique case (state_q)
        ST_IDLE: begin
          // a frame only opens on a fresh falling select
          if (sel_fall && link_en_q) begin
            state_q <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (sel_n_s) begin
            state_q <= ST_IDLE;
          end else if (word_done) begin
            state_q <= ST_SPENT;
          end
        end
        ST_SPENT: begin
          // extra clocks are dropped until select goes high again
          if (sel_n_s) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      shift_q   <= '0;
      bit_cnt_q <= '0;
    end else if (ce) begin
      if (state_q != ST_SHIFT || sel_n_s) begin
        bit_cnt_q <= '0;
      end else if (sclk_fall) begin
        shift_q   <= word;
        bit_cnt_q <= bit_cnt_q + CNT_W'(1);
      end
    end
  end

  // ---------------------------------------------------------------
  // command decode at the sixteenth edge
  // ---------------------------------------------------------------
  logic [1:0]        cmd_addr;
  logic [1:0]        cmd_mode;
  logic [CODE_W-1:0] cmd_code;

  assign cmd_addr = word[ADDR_MSB:ADDR_LSB];
  assign cmd_mode = word[MODE_MSB:MODE_LSB];
  assign cmd_code = word[CODE_MSB:CODE_LSB];

  logic [CODE_W-1:0] pend_q [NUM_CH];
  logic [CODE_W-1:0] out_q  [NUM_CH];

  // pending codes: every write mode loads the addressed channel
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < NUM_CH; i++) begin
        pend_q[i] <= CODE_RST;
      end
    end else if (ce) begin
      if (word_done && cmd_mode != MODE_PDOWN) begin
        pend_q[cmd_addr] <= cmd_code;
      end
    end
  end

  // applied codes stay at zero until a complete frame asks for an update
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < NUM_CH; i++) begin
        out_q[i] <= CODE_RST;
      end
    end else if (ce && word_done) begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (cmd_mode == MODE_SINGLE && cmd_addr == 2'(i)) begin
          out_q[i] <= cmd_code;
        end else if (cmd_mode == MODE_ALL) begin
          // all four move together, the addressed one with its new code
          out_q[i] <= (cmd_addr == 2'(i)) ? cmd_code : pend_q[i];
        end
      end
    end
  end

  // power-down: option lives in the channel field; code zero is not an option
  logic       pd_q;
  logic [1:0] pdo_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pd_q  <= 1'b0;
      pdo_q <= PD_RESERVED;
    end else if (ce && word_done) begin
      if (cmd_mode == MODE_PDOWN && cmd_addr != PD_RESERVED) begin
        pd_q  <= 1'b1;
        pdo_q <= cmd_addr;
      end else if (cmd_mode == MODE_SINGLE || cmd_mode == MODE_ALL) begin
        pd_q  <= 1'b0;
        pdo_q <= PD_RESERVED;
      end
    end
  end

  assign channel_a_output = out_q[0];
  assign channel_b_output = out_q[1];
  assign channel_c_output = out_q[2];
  assign channel_d_output = out_q[3];
  assign power_down       = pd_q;
  assign pd_option        = pdo_q;

  // ---------------------------------------------------------------
  // statistics
  // ---------------------------------------------------------------
  logic [7:0]            done_cnt_q;
  logic [7:0]            abort_cnt_q;
  logic [FRAME_BITS-1:0] last_word_q;
  logic                  cnt_clear;

  // counters wrap; a frame event in the clear cycle still counts
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      done_cnt_q  <= '0;
      abort_cnt_q <= '0;
      last_word_q <= '0;
    end else if (ce) begin
      if (word_done) begin
        last_word_q <= word;
        done_cnt_q  <= cnt_clear ? 8'h01 : done_cnt_q + 8'h01;
      end else if (cnt_clear) begin
        done_cnt_q  <= '0;
      end
      if (frame_abort) begin
        abort_cnt_q <= cnt_clear ? 8'h01 : abort_cnt_q + 8'h01;
      end else if (cnt_clear) begin
        abort_cnt_q <= '0;
      end
    end
  end

  // ---------------------------------------------------------------
  // apb slave: one wait state, answer in the second access cycle
  // ---------------------------------------------------------------
  logic access;
  logic wr_fire;
  logic hit;

  assign access    = psel & penable & ~pready;
  assign wr_fire   = psel & penable & pready & pwrite;
  assign cnt_clear = wr_fire && paddr == OFS_CTRL && pwdata[CTRL_CLR_BIT];

  always_comb begin
    unique case (paddr)
      OFS_CTRL, OFS_STATUS, OFS_CODES, OFS_LAST, OFS_PENDING: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  // disabling the link leaves a frame in progress to finish normally
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      link_en_q <= CTRL_EN_RST;
    end else if (ce && wr_fire && paddr == OFS_CTRL) begin
      link_en_q <= pwdata[CTRL_EN_BIT];
    end
  end

  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = DATA_ZERO;
    unique case (paddr)
      OFS_CTRL: begin
        rd_mux[CTRL_EN_BIT] = link_en_q;
      end
      OFS_STATUS: begin
        rd_mux[ST_DONE_LSB +: 8]  = done_cnt_q;
        rd_mux[ST_ABORT_LSB +: 8] = abort_cnt_q;
        rd_mux[ST_BUSY_BIT]       = (state_q == ST_SHIFT);
        rd_mux[ST_PD_BIT]         = pd_q;
        rd_mux[ST_PDO_LSB +: 2]   = pdo_q;
      end
      OFS_CODES: begin
        rd_mux = {out_q[3], out_q[2], out_q[1], out_q[0]};
      end
      OFS_LAST: begin
        rd_mux[FRAME_BITS-1:0] = last_word_q;
      end
      OFS_PENDING: begin
        rd_mux = {pend_q[3], pend_q[2], pend_q[1], pend_q[0]};
      end
      default: begin
        rd_mux = DATA_ZERO;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= DATA_ZERO;
    end else if (ce) begin
      pready  <= access;
      pslverr <= access & ~hit;
      if (access && !pwrite) begin
        prdata <= rd_mux;
      end
    end
  end

endmodule
`default_nettype wire

/* File: test/serial_master.sv */
// behavioural three-wire serial master for the converter link
`timescale 1ns/10ps
`default_nettype none
module serial_master (
  output var logic frame_sel_n,
  output var logic serial_clk,
  output var logic serial_din
);
  initial begin
    frame_sel_n = 1'b1;
    serial_clk  = 1'b1;
    serial_din  = 1'b0;
  end
  // fewer than 16 falls models an aborted frame, more models overclocking
  task automatic send(input logic [15:0] w, input int nfalls);
    #3 frame_sel_n = 1'b0;
    for (int i = 0; i < nfalls; i++) begin
      serial_din = (i < 16) ? w[15-i] : ~serial_din;
      #32 serial_clk = 1'b0;
      #32 serial_clk = 1'b1;
    end
    #32 frame_sel_n = 1'b1;
    // released data line flips so a stale bit never looks driven
    serial_din = ~serial_din;
  endtask
endmodule
`default_nettype wire

/* File: test/dac_update_ctrl_checker.sv */
// port-level assertions for the quad converter update control
`timescale 1ns/10ps
`default_nettype none
module dac_update_ctrl_checker
  import dac_link_pkg::*;
(
  input wire logic                            clk,
  input wire logic                            resetn,
  input wire logic                            ce,
  input wire logic                            frame_sel_n,
  input wire logic                            serial_clk,
  input wire logic                            psel,
  input wire logic                            penable,
  input wire logic                            pwrite,
  input wire logic [31:0]                     prdata,
  input wire logic                            pready,
  input wire logic                            pslverr,
  input wire logic [dac_link_pkg::CODE_W-1:0] channel_a_output,
  input wire logic [dac_link_pkg::CODE_W-1:0] channel_b_output,
  input wire logic [dac_link_pkg::CODE_W-1:0] channel_c_output,
  input wire logic [dac_link_pkg::CODE_W-1:0] channel_d_output,
  input wire logic                            power_down,
  input wire logic [1:0]                      pd_option
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  wire logic [31:0] codes = {channel_a_output, channel_b_output,
                             channel_c_output, channel_d_output};
  ready_answer_a: assert property (ce && psel && penable && !pready |=> pready)
    else $error("access phase not answered next cycle");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held beyond one cycle");
  error_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  rdata_hold_a: assert property (!$stable(prdata) |-> pready && !pwrite)
    else $error("read data moved outside a read answer");
  reset_zero_a: assert property ($rose(resetn) |-> codes == 32'h0000_0000)
    else $error("outputs not zero after reset");
  update_frame_a: assert property (
    !$stable(codes) |-> $past(!frame_sel_n && !serial_clk, 3))
    else $error("outputs moved outside a frame end");
  idle_still_a: assert property (frame_sel_n [*8] |=> $stable({codes, power_down}))
    else $error("outputs moved while deselected");
  pd_quiet_a: assert property (!power_down |-> pd_option == 2'h0)
    else $error("termination choice while active");
  pd_choice_a: assert property (power_down |-> pd_option != PD_RESERVED)
    else $error("reserved termination applied");
endmodule
`default_nettype wire

/* File: test/test_quad_dac_serial_update_control.sv */
// self-checking bench for the quad converter serial update control
`timescale 1ns/10ps
`default_nettype none
module test_quad_dac_serial_update_control;
  import dac_link_pkg::*;
  logic              clk = 1'b0;
  logic              resetn = 1'b0;
  logic              ce = 1'b1;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = 12'h000;
  logic [31:0]       pwdata = 32'h0000_0000;
  logic [31:0]       prdata, rd;
  logic              pready, pslverr, power_down, err;
  logic [7:0]        ch_a, ch_b, ch_c, ch_d;
  logic [1:0]        pd_option;
  wire logic         frame_sel_n, serial_clk, serial_din;
  wire logic [34:0]  outs = {ch_a, ch_b, ch_c, ch_d, power_down, pd_option};
  int                failures = 0;
  int                cmp_count = 0;
  int                cyc = 0;
  logic [15:0] row_w [9] = '{16'h15a0, 16'h5a50, 16'h83c0, 16'hec30, 16'h7000,
                             16'hb000, 16'hf000, 16'h3000, 16'h1ff0};
  logic [34:0] row_e [9] = '{{32'h5a00_0000, 3'h0}, {32'h5aa5_0000, 3'h0},
    {32'h5aa5_0000, 3'h0}, {32'h5aa5_3cc3, 3'h0}, {32'h5aa5_3cc3, 3'h5},
    {32'h5aa5_3cc3, 3'h6}, {32'h5aa5_3cc3, 3'h7}, {32'h5aa5_3cc3, 3'h7},
    {32'hffa5_3cc3, 3'h0}};
  always #4 clk = ~clk;
  dac_update_ctrl u_dac_update_ctrl (.clk(clk), .resetn(resetn), .ce(ce),
    .frame_sel_n(frame_sel_n), .serial_clk(serial_clk), .serial_din(serial_din),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .channel_a_output(ch_a),
    .channel_b_output(ch_b), .channel_c_output(ch_c), .channel_d_output(ch_d),
    .power_down(power_down), .pd_option(pd_option));
  serial_master u_serial_master (.frame_sel_n(frame_sel_n), .serial_clk(serial_clk),
    .serial_din(serial_din));
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk_out(input logic [34:0] e);
    cmp_count++;
    if (outs !== e) begin
      failures++;
      $display("MISMATCH %0t outputs %h expected %h", $time, outs, e);
    end
  endtask
  task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %0t word %h expected %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // no local limit: a hang is ended by the cycle ceiling and counted there
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // select stays high at least six clocks so the synchronisers settle
  task automatic frame(input logic [15:0] w, input int n);
    u_serial_master.send(w, n);
    repeat (6) @(posedge clk);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      end_sim;
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    chk_out(35'h0_0000_0000);
    for (int i = 0; i < 9; i++) begin
      frame(row_w[i], 16);
      chk_out(row_e[i]);
      $display("row %0d done", i);
    end
    frame(16'h1110, 10);
    chk_out(row_e[8]);
    apb(1'b0, OFS_STATUS, 32'h0000_0000);
    chk_word({24'h00_0000, rd[15:8]}, 32'h0000_0001);
    $display("abort test done");
    frame(16'h5220, 20);
    apb(1'b0, OFS_LAST, 32'h0000_0000);
    chk_word({16'h0000, rd[15:0]}, 32'h0000_5220);
    apb(1'b0, OFS_CODES, 32'h0000_0000);
    chk_word(rd, 32'hc33c_22ff);
    $display("overclock test done");
    // load-only frame: pending moves, applied codes do not
    frame(16'h8110, 16);
    chk_out({32'hff22_3cc3, 3'h0});
    apb(1'b0, OFS_PENDING, 32'h0000_0000);
    chk_word(rd, 32'hc311_22ff);
    $display("pending test done");
    apb(1'b0, 12'h020, 32'h0000_0000);
    chk_word({31'h0000_0000, err}, 32'h0000_0001);
    chk_word(rd, 32'h0000_0000);
    apb(1'b0, OFS_CTRL, 32'h0000_0000);
    chk_word(rd, 32'h0000_0001);
    apb(1'b1, OFS_CTRL, 32'h0000_0000);
    frame(16'h9770, 16);
    chk_out({32'hff22_3cc3, 3'h0});
    apb(1'b0, OFS_STATUS, 32'h0000_0000);
    chk_word(rd, 32'h0000_010b);
    // re-enable and clear both counters in one write
    apb(1'b1, OFS_CTRL, 32'h0000_0003);
    apb(1'b0, OFS_STATUS, 32'h0000_0000);
    chk_word(rd, 32'h0000_0000);
    apb(1'b0, OFS_CTRL, 32'h0000_0000);
    chk_word(rd, 32'h0000_0001);
    $display("register test done");
    // a frame sent while the clock enable is low must leave no trace
    ce <= 1'b0;
    frame(16'h2440, 16);
    ce <= 1'b1;
    repeat (4) @(posedge clk);
    chk_out({32'hff22_3cc3, 3'h0});
    $display("enable test done");
    resetn <= 1'b0;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    chk_out(35'h0_0000_0000);
    frame(row_w[0], 16);
    chk_out(row_e[0]);
    $display("reset test done");
    end_sim;
  end
endmodule
bind dac_update_ctrl dac_update_ctrl_checker u_dac_update_ctrl_checker (.clk(clk),
  .resetn(resetn), .ce(ce), .frame_sel_n(frame_sel_n), .serial_clk(serial_clk),
  .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .channel_a_output(channel_a_output),
  .channel_b_output(channel_b_output), .channel_c_output(channel_c_output),
  .channel_d_output(channel_d_output), .power_down(power_down), .pd_option(pd_option));
`default_nettype wire
